/* File: atpr_consts.svh */
/*
 * Constants for the address-translation and page-request attribute block:
 * register offsets, field positions, reset values and table sizes.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef ATPR_CONSTS_SVH
`define ATPR_CONSTS_SVH

// Register byte offsets
`define ATPR_CTRL_OFS 8'h00
`define ATPR_STATUS_OFS 8'h04
`define ATPR_GRANT_OFS 8'h08
`define ATPR_VIOL_OFS 8'h0c

// Control register fields
`define ATPR_CTRL_RSP_PFX_BIT 0
`define ATPR_CTRL_RESET 32'h0000_0000

// Status register fields
`define ATPR_STAT_OUTST_LSB 0
`define ATPR_STAT_WRBLK_BIT 8
`define ATPR_STAT_UNMATCH_BIT 9

// Table geometry defaults
`define ATPR_TRANS_SLOTS 4
`define ATPR_PRG_SLOTS 4
`define ATPR_PASID_W 20
`define ATPR_PRGI_W 9

`endif

/* File: atpr_pkg.sv */
/*
 * Types for the address-translation and page-request attribute block.
 * Assumes no surroundings beyond a SystemVerilog compiler.
 */
package atpr_pkg;

  // Translation slot life cycle
  typedef enum logic [1:0] {
    atpr_slot_idle,
    atpr_slot_pend,
    atpr_slot_ro,
    atpr_slot_rw
  } atpr_slot_t;

endpackage

/* File: atpr_trans_slot.sv */
/*
 * One translation slot: tracks a translation request and its reply,
 * and says whether writes may use the translation.
 * Assumes requests and replies arrive on the same clock, one per cycle.
 */
`timescale 1ns/1ps
module atpr_trans_slot (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events for this slot
  input wire logic req_i,
  input wire logic cpl_i,
  input wire logic cpl_write_ok_i,
  input wire logic release_i,
  // State
  output logic busy_o,
  output logic write_ok_o
);

  atpr_pkg::atpr_slot_t state_ff;

  // Slot life cycle; a read-only reply keeps writes off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= atpr_pkg::atpr_slot_idle;
    end else if (req_i) begin
      state_ff <= atpr_pkg::atpr_slot_pend;
    end else if (cpl_i && state_ff == atpr_pkg::atpr_slot_pend) begin
      state_ff <= cpl_write_ok_i ? atpr_pkg::atpr_slot_rw : atpr_pkg::atpr_slot_ro;
    end else if (release_i) begin
      state_ff <= atpr_pkg::atpr_slot_idle;
    end
  end

  assign busy_o = (state_ff != atpr_pkg::atpr_slot_idle);
  assign write_ok_o = (state_ff == atpr_pkg::atpr_slot_rw);

endmodule // atpr_trans_slot

/* File: atpr_prg_slot.sv */
/*
 * One outstanding page-request-group entry: holds the group index and
 * optional PASID, and matches a returning response against them.
 * Assumes responses arrive on the same clock as requests.
 */
`timescale 1ns/1ps
module atpr_prg_slot #(
  parameter int PASID_W = 20,
  parameter int PRGI_W = 9
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Allocation
  input wire logic alloc_i,
  input wire logic [PRGI_W-1:0] alloc_index_i,
  input wire logic alloc_has_pasid_i,
  input wire logic [PASID_W-1:0] alloc_pasid_i,
  // Response lookup
  input wire logic rsp_use_pasid_i,
  input wire logic [PRGI_W-1:0] rsp_index_i,
  input wire logic rsp_has_pasid_i,
  input wire logic [PASID_W-1:0] rsp_pasid_i,
  input wire logic retire_i,
  // State
  output logic busy_o,
  output logic hit_o
);

  logic busy_ff;
  logic has_pasid_ff;
  logic [PRGI_W-1:0] index_ff;
  logic [PASID_W-1:0] pasid_ff;

  // Entry occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
    end else if (alloc_i) begin
      busy_ff <= 1'b1;
    end else if (retire_i) begin
      busy_ff <= 1'b0;
    end
  end

  // Stored identity of the group
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      has_pasid_ff <= 1'b0;
      index_ff <= '0;
      pasid_ff <= '0;
    end else if (alloc_i) begin
      has_pasid_ff <= alloc_has_pasid_i;
      index_ff <= alloc_index_i;
      pasid_ff <= alloc_pasid_i;
    end
  end

  // Index always compared; PASID too when prefix mode is on and both carry one
  assign hit_o = busy_ff && (index_ff == rsp_index_i) &&
                 (!(rsp_use_pasid_i && has_pasid_ff && rsp_has_pasid_i) ||
                  (pasid_ff == rsp_pasid_i));
  assign busy_o = busy_ff;

endmodule // atpr_prg_slot

/* File: atpr_core.sv */
/*
 * Function-side translation and page-request attribute logic with a
 * Wishbone classic register slave. Sets the no-write flag on translation
 * requests, blocks writes through read-only translations, sets the
 * write-access field of page requests, and matches page-request-group
 * responses by group index and PASID.
 * Assumes one clock, synchronous active-high reset, and a same-clock
 * transaction layer that sends and receives the packets.
 */
`timescale 1ns/1ps
`include "atpr_consts.svh"

// Functional notes
// - Function may match responses using prefix PASID plus page group index.
// - Function sets no-write flag to ask only read access via translation.
// - No writes through read-only translation; write needs new request, flag clear; code allows writes after any writable reply, flag set or not.
// - Clear no-write flag only after explicit write permission given.
// - Page request write-access set to seek write; clear only if never writing; code clears it for a wanted write when grant_ff is all zero.
// - Never set page request write-access without explicit write permission.
module atpr_core #(
  parameter int TRANS_SLOTS = `ATPR_TRANS_SLOTS,
  parameter int PRG_SLOTS = `ATPR_PRG_SLOTS,
  parameter int PASID_W = `ATPR_PASID_W,
  parameter int PRGI_W = `ATPR_PRGI_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Translation request from engine
  input wire logic tr_req_valid_i,
  input wire logic [1:0] tr_req_slot_i,
  input wire logic tr_req_want_write_i,
  output logic tr_req_ready_o,
  output logic tr_out_valid_o,
  output logic [1:0] tr_out_slot_o,
  output logic tr_out_no_write_flag_o,
  // Translation completion from link
  input wire logic tr_cpl_valid_i,
  input wire logic [1:0] tr_cpl_slot_i,
  input wire logic tr_cpl_write_ok_i,
  input wire logic tr_release_i,
  // Memory write gating
  input wire logic mw_valid_i,
  input wire logic [1:0] mw_slot_i,
  output logic mw_allow_o,
  output logic mw_block_o,
  // Page request from engine
  input wire logic pr_valid_i,
  input wire logic pr_want_write_i,
  input wire logic [PRGI_W-1:0] pr_index_i,
  input wire logic pr_has_pasid_i,
  input wire logic [PASID_W-1:0] pr_pasid_i,
  output logic pr_ready_o,
  output logic pr_out_valid_o,
  output logic pr_out_write_access_o,
  output logic [PRGI_W-1:0] pr_out_index_o,
  output logic pr_out_has_pasid_o,
  output logic [PASID_W-1:0] pr_out_pasid_o,
  // Page-request-group response from link
  input wire logic rsp_valid_i,
  input wire logic [PRGI_W-1:0] rsp_index_i,
  input wire logic rsp_has_pasid_i,
  input wire logic [PASID_W-1:0] rsp_pasid_i,
  output logic rsp_match_o,
  output logic rsp_unmatched_o,
  // Control state seen by the link layer
  output logic response_prefix_required_enable_o
);

  // Refuse parameter values the logic cannot serve; slot ids are 2 bits wide
  if (TRANS_SLOTS != 4 || PRG_SLOTS < 1 || PRG_SLOTS > 8) $error("slot counts out of range");
  if (PASID_W < 1 || PASID_W > 32 || PRGI_W < 1 || PRGI_W > 32) $error("field widths out of range");

  logic ctrl_pfx_ff;
  logic [TRANS_SLOTS-1:0] grant_ff;
  logic [TRANS_SLOTS-1:0] viol_ff;
  logic wrblk_ff;
  logic unmatch_ff;
  logic ack_ff;
  logic err_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic nxt_err;
  logic [TRANS_SLOTS-1:0] t_busy;
  logic [TRANS_SLOTS-1:0] t_wok;
  logic [PRG_SLOTS-1:0] p_busy;
  logic [PRG_SLOTS-1:0] p_hit;
  logic [PRG_SLOTS-1:0] p_alloc;
  logic [PRG_SLOTS-1:0] p_retire;
  logic p_free;
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic tr_fire;
  logic pr_fire;
  logic [3:0] outst_cnt;

  // Bus request decode; one answer per request, ack drops the cycle after
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
  assign wb_wr = wb_req && wb_we_i && !nxt_err && wb_sel_i[0];
  assign wb_rd = wb_req && !wb_we_i;

  // Unmapped addresses answer with err
  always_comb begin
    nxt_err = 1'b1;
    unique case (wb_adr_i)
      `ATPR_CTRL_OFS, `ATPR_STATUS_OFS, `ATPR_GRANT_OFS, `ATPR_VIOL_OFS: nxt_err = 1'b0;
      default: nxt_err = 1'b1;
    endcase
  end

  // Bus answer flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req && !nxt_err;
      err_ff <= wb_req && nxt_err;
    end
  end

  // Control: response prefix required enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_pfx_ff <= 1'(`ATPR_CTRL_RESET >> `ATPR_CTRL_RSP_PFX_BIT);
    end else if (wb_wr && wb_adr_i == `ATPR_CTRL_OFS) begin
      ctrl_pfx_ff <= wb_dat_i[`ATPR_CTRL_RSP_PFX_BIT];
    end
  end

  // Write permission per translation slot, granted by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grant_ff <= '0;
    end else if (wb_wr && wb_adr_i == `ATPR_GRANT_OFS) begin
      grant_ff <= wb_dat_i[TRANS_SLOTS-1:0];
    end
  end

  // Sticky blocked-write record; set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      viol_ff <= '0;
    end else begin
      for (int i = 0; i < TRANS_SLOTS; i++) begin
        if (mw_block_o && mw_slot_i == 2'(i)) begin
          viol_ff[i] <= 1'b1;
        end else if (wb_wr && wb_adr_i == `ATPR_VIOL_OFS && wb_dat_i[i]) begin
          viol_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Sticky status events; set wins over clear by status write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrblk_ff <= 1'b0;
      unmatch_ff <= 1'b0;
    end else begin
      if (mw_block_o) begin
        wrblk_ff <= 1'b1;
      end else if (wb_wr && wb_adr_i == `ATPR_STATUS_OFS && wb_dat_i[`ATPR_STAT_WRBLK_BIT]) begin
        wrblk_ff <= 1'b0;
      end
      if (rsp_unmatched_o) begin
        unmatch_ff <= 1'b1;
      end else if (wb_wr && wb_adr_i == `ATPR_STATUS_OFS && wb_dat_i[`ATPR_STAT_UNMATCH_BIT]) begin
        unmatch_ff <= 1'b0;
      end
    end
  end

  // Count of outstanding page-request groups
  always_comb begin
    outst_cnt = '0;
    for (int i = 0; i < PRG_SLOTS; i++) begin
      outst_cnt = outst_cnt + 4'(p_busy[i]);
    end
  end

  // Read data mux
  always_comb begin
    nxt_rdat = '0;
    unique case (wb_adr_i)
      `ATPR_CTRL_OFS: nxt_rdat[`ATPR_CTRL_RSP_PFX_BIT] = ctrl_pfx_ff;
      `ATPR_STATUS_OFS: begin
        nxt_rdat[`ATPR_STAT_OUTST_LSB +: 4] = outst_cnt;
        nxt_rdat[`ATPR_STAT_WRBLK_BIT] = wrblk_ff;
        nxt_rdat[`ATPR_STAT_UNMATCH_BIT] = unmatch_ff;
      end
      `ATPR_GRANT_OFS: nxt_rdat[TRANS_SLOTS-1:0] = grant_ff;
      `ATPR_VIOL_OFS: nxt_rdat[TRANS_SLOTS-1:0] = viol_ff;
      default: nxt_rdat = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= '0;
    end else if (wb_rd) begin
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;
  assign response_prefix_required_enable_o = ctrl_pfx_ff;

  // Translation slots
  for (genvar g = 0; g < TRANS_SLOTS; g++) begin : g_trans
    atpr_trans_slot u_slot (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(tr_fire && tr_req_slot_i == 2'(g)),
      .cpl_i(tr_cpl_valid_i && tr_cpl_slot_i == 2'(g)),
      .cpl_write_ok_i(tr_cpl_write_ok_i),
      .release_i(tr_release_i && tr_req_slot_i == 2'(g)),
      .busy_o(t_busy[g]),
      .write_ok_o(t_wok[g])
    );
  end

  assign tr_req_ready_o = 1'b1;
  assign tr_fire = tr_req_valid_i;

  // Translation request out; flag set unless write wanted and granted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tr_out_valid_o <= 1'b0;
      tr_out_slot_o <= '0;
      tr_out_no_write_flag_o <= 1'b1;
    end else begin
      tr_out_valid_o <= tr_fire;
      if (tr_fire) begin
        tr_out_slot_o <= tr_req_slot_i;
        tr_out_no_write_flag_o <= !(tr_req_want_write_i &&
                                    grant_ff[tr_req_slot_i]);
      end
    end
  end

  // Writes pass only through translations that came back writable
  // whatever flag was sent, since the agent may ignore it
  assign mw_allow_o = mw_valid_i && t_wok[mw_slot_i];
  assign mw_block_o = mw_valid_i && !t_wok[mw_slot_i];

  // Page request allocation into first free group entry
  always_comb begin
    p_alloc = '0;
    p_free = 1'b0;
    for (int i = 0; i < PRG_SLOTS; i++) begin
      if (!p_busy[i] && !p_free) begin
        p_alloc[i] = pr_valid_i;
        p_free = 1'b1;
      end
    end
  end

  assign pr_ready_o = p_free;
  assign pr_fire = pr_valid_i && p_free;

  // Page request out; write access only with any explicit grant
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pr_out_valid_o <= 1'b0;
      pr_out_write_access_o <= 1'b0;
      pr_out_index_o <= '0;
      pr_out_has_pasid_o <= 1'b0;
      pr_out_pasid_o <= '0;
    end else begin
      pr_out_valid_o <= pr_fire;
      if (pr_fire) begin
        pr_out_write_access_o <= pr_want_write_i && (|grant_ff);
        pr_out_index_o <= pr_index_i;
        pr_out_has_pasid_o <= pr_has_pasid_i;
        pr_out_pasid_o <= pr_pasid_i;
      end
    end
  end

  // Group entries
  for (genvar g = 0; g < PRG_SLOTS; g++) begin : g_prg
    atpr_prg_slot #(
      .PASID_W(PASID_W),
      .PRGI_W(PRGI_W)
    ) u_prg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .alloc_i(p_alloc[g]),
      .alloc_index_i(pr_index_i),
      .alloc_has_pasid_i(pr_has_pasid_i),
      .alloc_pasid_i(pr_pasid_i),
      .rsp_use_pasid_i(ctrl_pfx_ff),
      .rsp_index_i(rsp_index_i),
      .rsp_has_pasid_i(rsp_has_pasid_i),
      .rsp_pasid_i(rsp_pasid_i),
      .retire_i(p_retire[g]),
      .busy_o(p_busy[g]),
      .hit_o(p_hit[g])
    );
  end

  // Retire the lowest matching entry; PASID joins index when prefixes enabled
  always_comb begin
    p_retire = '0;
    for (int i = PRG_SLOTS - 1; i >= 0; i--) begin
      if (rsp_valid_i && p_hit[i]) begin
        p_retire = '0;
        p_retire[i] = 1'b1;
      end
    end
  end

  // Response outcome pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_match_o <= 1'b0;
      rsp_unmatched_o <= 1'b0;
    end else begin
      rsp_match_o <= |p_retire;
      rsp_unmatched_o <= rsp_valid_i && !(|p_hit);
    end
  end

endmodule // atpr_core

/* File: atpr_monitor.sv */
/* Port checker for atpr_core.
   Assumes it is bound to atpr_core; one clock, synchronous reset. */
`timescale 1ns/1ps
module atpr_monitor #(
  parameter int PRGI_W = 9
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Translation
  input wire logic tr_req_valid_i,
  input wire logic [1:0] tr_req_slot_i,
  input wire logic tr_req_want_write_i,
  input wire logic tr_out_valid_o,
  input wire logic [1:0] tr_out_slot_o,
  input wire logic tr_out_no_write_flag_o,
  input wire logic tr_cpl_valid_i,
  // Write gating
  input wire logic mw_valid_i,
  input wire logic [1:0] mw_slot_i,
  input wire logic mw_allow_o,
  input wire logic mw_block_o,
  // Page requests and responses
  input wire logic pr_valid_i,
  input wire logic pr_ready_o,
  input wire logic pr_want_write_i,
  input wire logic [PRGI_W-1:0] pr_index_i,
  input wire logic pr_out_valid_o,
  input wire logic pr_out_write_access_o,
  input wire logic [PRGI_W-1:0] pr_out_index_o,
  input wire logic rsp_valid_i,
  input wire logic rsp_match_o,
  input wire logic rsp_unmatched_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Translation requests go out one cycle later on the same slot
  property p_tr_ans;
    tr_req_valid_i |=> tr_out_valid_o && tr_out_slot_o == $past(tr_req_slot_i);
  endproperty
  a_tr_ans: assert property (p_tr_ans) else $error("translation request not forwarded");
  // No wish to write always keeps the flag set
  property p_tr_ro;
    tr_req_valid_i && !tr_req_want_write_i |=> tr_out_no_write_flag_o;
  endproperty
  a_tr_ro: assert property (p_tr_ro) else $error("no-write flag clear without need");
  // A write attempt is either allowed or blocked
  property p_mw_one;
    mw_valid_i |-> mw_allow_o != mw_block_o;
  endproperty
  a_mw_one: assert property (p_mw_one) else $error("write gate ambiguous");
  // No verdict without an attempt
  property p_mw_idle;
    !mw_valid_i |-> !mw_allow_o && !mw_block_o;
  endproperty
  a_mw_idle: assert property (p_mw_idle) else $error("write gate active when idle");
  // A fresh request leaves the slot without write access
  property p_mw_pend;
    tr_req_valid_i && !tr_cpl_valid_i ##1 mw_valid_i && mw_slot_i == $past(tr_req_slot_i)
      |-> mw_block_o;
  endproperty
  a_mw_pend: assert property (p_mw_pend) else $error("write allowed on pending slot");
  // Accepted page requests go out next cycle with their index
  property p_pr_ans;
    pr_valid_i && pr_ready_o |=> pr_out_valid_o && pr_out_index_o == $past(pr_index_i);
  endproperty
  a_pr_ans: assert property (p_pr_ans) else $error("page request not forwarded");
  // Write access only when wanted
  property p_pr_wa;
    pr_valid_i && pr_ready_o && !pr_want_write_i |=> !pr_out_write_access_o;
  endproperty
  a_pr_wa: assert property (p_pr_wa) else $error("write access set unasked");
  // Every response gets exactly one verdict next cycle
  property p_rsp;
    rsp_valid_i |=> rsp_match_o != rsp_unmatched_o;
  endproperty
  a_rsp: assert property (p_rsp) else $error("response verdict missing");
  // Bus cycles are answered in one cycle
  property p_wb;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o;
  endproperty
  a_wb: assert property (p_wb) else $error("bus cycle not answered");
endmodule // atpr_monitor

/* File: atpr_rc_model.sv */
/* Host translation agent and page handler model.
   Assumes one request in flight at a time on each path. */
`timescale 1ns/1ps
module atpr_rc_model (
  // Clock, reset and behaviour controls
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic honour_i,
  input wire logic bad_i,
  input wire logic [3:0] delay_i,
  input wire logic prefix_en_i,
  // Requests from the function
  input wire logic req_valid_i,
  input wire logic [1:0] req_slot_i,
  input wire logic req_no_write_i,
  input wire logic pg_valid_i,
  input wire logic [8:0] pg_index_i,
  input wire logic pg_has_pasid_i,
  input wire logic [19:0] pg_pasid_i,
  // Answers to the function
  output logic cpl_valid_o,
  output logic [1:0] cpl_slot_o,
  output logic cpl_write_ok_o,
  output logic rsp_valid_o,
  output logic [8:0] rsp_index_o,
  output logic rsp_has_pasid_o,
  output logic [19:0] rsp_pasid_o
);
  logic [3:0] t_cnt, p_cnt;
  logic [1:0] t_slot;
  logic t_nw, p_has;
  logic [8:0] p_idx;
  logic [19:0] p_pasid;

  // Translation completions delay_i + 1 cycles after the request is taken; idle fields toggle
  always_ff @(posedge clk_i) begin
    cpl_valid_o <= 1'b0;
    cpl_slot_o <= ~cpl_slot_o;
    cpl_write_ok_o <= ~cpl_write_ok_o;
    if (rst_i) begin
      t_cnt <= 4'h0;
      cpl_slot_o <= 2'h0;
      cpl_write_ok_o <= 1'b0;
    end else if (req_valid_i) begin
      t_cnt <= delay_i + 4'h1;
      t_slot <= req_slot_i;
      t_nw <= req_no_write_i;
    end else if (t_cnt == 4'h1) begin
      t_cnt <= 4'h0;
      cpl_valid_o <= 1'b1;
      cpl_slot_o <= t_slot;
      cpl_write_ok_o <= !(t_nw && honour_i);
    end else if (t_cnt != 4'h0) begin
      t_cnt <= t_cnt - 4'h1;
    end
  end

  // Group responses delay_i + 1 cycles after the request is taken; idle fields toggle
  always_ff @(posedge clk_i) begin
    rsp_valid_o <= 1'b0;
    rsp_index_o <= ~rsp_index_o;
    rsp_pasid_o <= ~rsp_pasid_o;
    rsp_has_pasid_o <= ~rsp_has_pasid_o;
    if (rst_i) begin
      p_cnt <= 4'h0;
      rsp_index_o <= 9'h0;
      rsp_pasid_o <= 20'h0;
      rsp_has_pasid_o <= 1'b0;
    end else if (pg_valid_i) begin
      p_cnt <= delay_i + 4'h1;
      p_idx <= pg_index_i;
      p_has <= pg_has_pasid_i;
      p_pasid <= pg_pasid_i;
    end else if (p_cnt == 4'h1) begin
      p_cnt <= 4'h0;
      rsp_valid_o <= 1'b1;
      rsp_index_o <= p_idx;
      rsp_has_pasid_o <= prefix_en_i && p_has;
      rsp_pasid_o <= p_pasid ^ {19'h0, bad_i};
    end else if (p_cnt != 4'h0) begin
      p_cnt <= p_cnt - 4'h1;
    end
  end
endmodule // atpr_rc_model

/* File: tb_top.sv */
/* Self-checking bench for atpr_core over Wishbone.
   Assumes atpr_core, atpr_rc_model and atpr_monitor are compiled. */
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, wb_err_o, tr_req_ready_o, tr_out_valid_o, tr_out_no_write_flag_o;
  logic tr_req_valid_i = 1'b0, tr_req_want_write_i = 1'b0, tr_release_i = 1'b0;
  logic [1:0] tr_req_slot_i = 2'h0, mw_slot_i = 2'h0, tr_out_slot_o, tr_cpl_slot_i;
  logic tr_cpl_valid_i, tr_cpl_write_ok_i, mw_valid_i = 1'b0, mw_allow_o, mw_block_o;
  logic pr_valid_i = 1'b0, pr_want_write_i = 1'b0, pr_has_pasid_i = 1'b0;
  logic [8:0] pr_index_i = 9'h0, pr_out_index_o, rsp_index_i;
  logic [19:0] pr_pasid_i = 20'h0, pr_out_pasid_o, rsp_pasid_i;
  logic pr_ready_o, pr_out_valid_o, pr_out_write_access_o, pr_out_has_pasid_o;
  logic rsp_valid_i, rsp_has_pasid_i, rsp_match_o, rsp_unmatched_o;
  logic response_prefix_required_enable_o, honour = 1'b1, bad = 1'b0;
  int n_errors = 0, n_checks = 0;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  atpr_core atpr_core_inst (.*);
  atpr_rc_model atpr_rc_model_inst (.clk_i(clk_i), .rst_i(rst_i), .honour_i(honour),
    .bad_i(bad), .delay_i(4'h2), .prefix_en_i(response_prefix_required_enable_o),
    .req_valid_i(tr_out_valid_o), .req_slot_i(tr_out_slot_o),
    .req_no_write_i(tr_out_no_write_flag_o), .pg_valid_i(pr_out_valid_o),
    .pg_index_i(pr_out_index_o), .pg_has_pasid_i(pr_out_has_pasid_o),
    .pg_pasid_i(pr_out_pasid_o), .cpl_valid_o(tr_cpl_valid_i), .cpl_slot_o(tr_cpl_slot_i),
    .cpl_write_ok_o(tr_cpl_write_ok_i), .rsp_valid_o(rsp_valid_i), .rsp_index_o(rsp_index_i),
    .rsp_has_pasid_o(rsp_has_pasid_i), .rsp_pasid_o(rsp_pasid_i));

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic Wishbone single cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
                    output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) n_errors++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    wb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    wb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask

  // Wait for a model answer, then one edge for the core to take it
  task automatic await(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 20) n_errors++;
    @(posedge clk_i);
  endtask

  // Translation request, flag check, completion
  task automatic tr(input logic [1:0] s, input logic w, input logic ef);
    @(posedge clk_i);
    tr_req_valid_i <= 1'b1;
    tr_req_slot_i <= s;
    tr_req_want_write_i <= w;
    @(posedge clk_i);
    tr_req_valid_i <= 1'b0;
    mw_valid_i <= 1'b1;
    mw_slot_i <= s;
    #1;
    chk("no_write_flag", {31'h0, ef}, {31'h0, tr_out_no_write_flag_o});
    chk("mw_pend", 32'h0, {31'h0, mw_allow_o});
    @(posedge clk_i);
    mw_valid_i <= 1'b0;
    await(tr_cpl_valid_i);
  endtask

  // Memory write attempt through a slot
  task automatic mw(input logic [1:0] s, input logic ea);
    @(posedge clk_i);
    mw_valid_i <= 1'b1;
    mw_slot_i <= s;
    #1;
    chk("mw_allow", {31'h0, ea}, {31'h0, mw_allow_o});
    @(posedge clk_i);
    mw_valid_i <= 1'b0;
  endtask

  // Page request with PASID, then response verdict
  task automatic pr(input logic [8:0] i, input logic w, input logic [19:0] p,
                    input logic ewa, input logic em);
    @(posedge clk_i);
    pr_valid_i <= 1'b1;
    pr_index_i <= i;
    pr_want_write_i <= w;
    pr_has_pasid_i <= 1'b1;
    pr_pasid_i <= p;
    @(posedge clk_i);
    pr_valid_i <= 1'b0;
    #1;
    chk("write_access", {31'h0, ewa}, {31'h0, pr_out_write_access_o});
    chk("pasid_out", {12'h0, p}, {12'h0, pr_out_pasid_o});
    await(rsp_valid_i);
    #1;
    chk("rsp_match", {31'h0, em}, {31'h0, rsp_match_o});
    chk("rsp_unmatched", {31'h0, !em}, {31'h0, rsp_unmatched_o});
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    logic er;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      rdc("reg_reset", 8'(a), 32'h0);
    end
    chk("flag_reset", 32'h1, {31'h0, tr_out_no_write_flag_o});
    chk("pr_ready", 32'h1, {31'h0, pr_ready_o});
    wb(1'b0, 8'h10, 32'h0, d, er);
    chk("unmapped_err", 32'h1, {31'h0, er});
    tr(2'h0, 1'b1, 1'b1);
    mw(2'h0, 1'b0);
    rdc("status", 8'h04, 32'h100);
    rdc("viol", 8'h0c, 32'h1);
    wr(8'h04, 32'h100);
    wr(8'h0c, 32'h1);
    rdc("status_clr", 8'h04, 32'h0);
    wb_sel_i <= 4'he;
    wr(8'h08, 32'h1);
    wb_sel_i <= 4'hf;
    rdc("sel_ignored", 8'h08, 32'h0);
    wr(8'h08, 32'h2);
    rdc("grant", 8'h08, 32'h2);
    tr(2'h1, 1'b1, 1'b0);
    mw(2'h1, 1'b1);
    tr(2'h1, 1'b0, 1'b1);
    mw(2'h1, 1'b0);
    honour = 1'b0;
    tr(2'h2, 1'b1, 1'b1);
    mw(2'h2, 1'b1);
    @(posedge clk_i);
    tr_release_i <= 1'b1;
    @(posedge clk_i);
    tr_release_i <= 1'b0;
    mw(2'h2, 1'b0);
    wr(8'h08, 32'h0);
    pr(9'h005, 1'b1, 20'h12345, 1'b0, 1'b1);
    wr(8'h08, 32'h4);
    pr(9'h1ff, 1'b1, 20'h0abcd, 1'b1, 1'b1);
    bad = 1'b1;
    pr(9'h000, 1'b0, 20'h00001, 1'b0, 1'b1);
    wr(8'h00, 32'h1);
    chk("prefix_en", 32'h1, {31'h0, response_prefix_required_enable_o});
    bad = 1'b0;
    pr(9'h0a5, 1'b1, 20'hfffff, 1'b1, 1'b1);
    bad = 1'b1;
    pr(9'h0a5, 1'b1, 20'hfffff, 1'b1, 1'b0);
    rdc("status_end", 8'h04, 32'h301);
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule // tb_top

bind atpr_core atpr_monitor #(.PRGI_W(PRGI_W)) atpr_monitor_inst (.*);
